// [hdl/fbp_defs.svh]
// Constants for the flash block protection logic
`ifndef FBP_DEFS_SVH
`define FBP_DEFS_SVH
`define FBP_FLASH_BYTES 32'h0001_0000
`define FBP_BLOCK_BYTES 32'h0000_0400
`define FBP_ADDR_W 16
`define FBP_BLOCK_LSB 10
`define FBP_GRAN_LSB 11
`define FBP_NUM_GRAN 32
`define FBP_ERASED_WORD 32'hffff_ffff
`define FBP_ERASE_CYCLES 16'h0010
`define FBP_PROG_CYCLES 16'h0004
`endif

// [hdl/fbp_pkg.sv]
// Types shared by the flash block protection logic
package fbp_pkg;
	typedef enum logic [1:0] {
		FBP_PROT_NONE = 2'h0,
		FBP_PROT_RO = 2'h1,
		FBP_PROT_XO = 2'h2
	} fbp_prot_e;
	typedef enum logic [1:0] {
		FBP_SRC_FETCH = 2'h0,
		FBP_SRC_DATA = 2'h1,
		FBP_SRC_DEBUG = 2'h2
	} fbp_src_e;
	typedef struct packed {
		logic valid;
		fbp_src_e src;
		logic [15:0] addr;
	} fbp_rd_req_s;
	typedef struct packed {
		logic valid;
		logic erase;
		logic [15:0] addr;
		logic [31:0] data;
	} fbp_wr_req_s;
endpackage : fbp_pkg

// [hdl/fbp_array.sv]
// Flash array model with word erase and word program
`timescale 1ns/100ps
`include "fbp_defs.svh"
module fbp_array import fbp_pkg::*; #(
	parameter int WORDS = 16384
) (
	input wire logic i_ref_clk,
	input wire logic i_rd_en,
	input wire logic [13:0] i_rd_word,
	output logic [31:0] o_rd_data,
	input wire logic i_prog,
	input wire logic i_erase_word,
	input wire logic [13:0] i_wr_word,
	input wire logic [31:0] i_wr_data
);
	logic [31:0] mem [0:WORDS-1];
	// Programming can only clear bits, as in real flash; erase sets them back
	always_ff @(posedge i_ref_clk) begin
		if (i_erase_word) begin
			mem[i_wr_word] <= `FBP_ERASED_WORD;
		end else if (i_prog) begin
			mem[i_wr_word] <= mem[i_wr_word] & i_wr_data;
		end
		if (i_rd_en) begin
			o_rd_data <= mem[i_rd_word];
		end
	end
endmodule : fbp_array

// [hdl/fbp_ctrl.sv]
// Flash block protection controller, top level
// Design notes
// The block sits between the requesters and the flash array. Reads come
// from three sources (fetch, data, debug) on one request port; writes are
// either a word program or a 1 KB block erase on a second port.
//
// Read path: a request is taken on the edge where its valid bit is high.
// The array is read on that edge, and the answer is registered once more,
// so o_rd_valid or o_rd_denied stands in the second cycle after the request.
// Denied reads never enable the array, so a protected word is never
// even latched inside the block.
//
// Write path: only one job runs at a time. A request that arrives while a
// job is running is ignored, not queued; callers wait for busy to drop.
// The protection code is looked at on the taking edge only, so a change of
// i_prot during a running job does not stop that job.
//
// Erase writes one word per cycle, which keeps the sequencer small at the
// cost of a 256-cycle busy time per block.
//
// Protection code 3 is unused and is treated as unprotected.
`timescale 1ns/100ps
`include "fbp_defs.svh"
module fbp_ctrl import fbp_pkg::*; #(
	parameter int NUM_GRAN = `FBP_NUM_GRAN
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [2*NUM_GRAN-1:0] i_prot,
	input wire fbp_rd_req_s i_rd,
	output logic o_rd_valid,
	output logic o_rd_denied,
	output logic [31:0] o_rd_data,
	input wire fbp_wr_req_s i_wr,
	output logic o_wr_busy,
	output logic o_wr_done,
	output logic o_wr_rejected
);
	typedef enum logic [2:0] {
		FBP_ST_IDLE = 3'b001,
		FBP_ST_ERASE = 3'b010,
		FBP_ST_PROG = 3'b100
	} fbp_state_e;

	// Protection lookup for the granule holding an address
	// Two adjacent 1 KB blocks share one 2-bit code, picked by addr[15:11]
	// Used by both ports, hence a function rather than two copies
	function automatic fbp_prot_e prot_of(input logic [2*NUM_GRAN-1:0] p, input logic [15:0] a);
		logic [4:0] g;
		g = a[15:`FBP_GRAN_LSB];
		prot_of = fbp_prot_e'(p[2*g +: 2]);
	endfunction : prot_of

	// Sequencer state and job registers
	// cnt_reg times a program job; ewrd_reg walks the words of an erase
	fbp_state_e state_reg, state_next;
	logic [15:0] cnt_reg;
	logic [9:0] ewrd_reg;
	logic [5:0] blk_reg;
	logic [13:0] pwrd_reg;
	logic [31:0] pdata_reg;
	logic rd_pend_reg;
	logic rd_deny_reg;
	logic [31:0] arr_data;

	// Read decode: execute-only granule only serves instruction fetch
	wire fbp_prot_e rd_prot = prot_of(i_prot, i_rd.addr);
	wire rd_deny = (rd_prot == FBP_PROT_XO) && (i_rd.src != FBP_SRC_FETCH);
	wire rd_go = i_rd.valid && !rd_deny;

	// Write decode: any protected granule refuses before the array is touched
	wire fbp_prot_e wr_prot = prot_of(i_prot, i_wr.addr);
	wire wr_locked = (wr_prot == FBP_PROT_RO) || (wr_prot == FBP_PROT_XO);
	wire wr_take = i_wr.valid && (state_reg == FBP_ST_IDLE);
	wire wr_start = wr_take && !wr_locked;
	wire wr_reject = wr_take && wr_locked;
	wire erasing = state_reg == FBP_ST_ERASE;
	wire prog_fire = (state_reg == FBP_ST_PROG) && (cnt_reg == 16'h0000);
	wire [13:0] wr_word = erasing ? {blk_reg, 8'h00} | {4'h0, ewrd_reg} : pwrd_reg;
	wire erase_last = erasing && (ewrd_reg == 10'h0ff);

	// Flash array; the read port and the write port work side by side,
	// so reads of other blocks go on while an erase runs
	fbp_array u_array (
		.i_ref_clk(i_ref_clk),
		.i_rd_en(rd_go),
		.i_rd_word(i_rd.addr[15:2]),
		.o_rd_data(arr_data),
		.i_prog(prog_fire),
		.i_erase_word(erasing),
		.i_wr_word(wr_word),
		.i_wr_data(pdata_reg)
	);

	// Next state of the erase/program sequencer
	// A refused request never leaves idle, so nothing of the array is touched
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			FBP_ST_IDLE: begin
				if (wr_start) begin
					state_next = i_wr.erase ? FBP_ST_ERASE : FBP_ST_PROG;
				end
			end
			FBP_ST_ERASE: begin
				if (erase_last) begin
					state_next = FBP_ST_IDLE;
				end
			end
			FBP_ST_PROG: begin
				if (prog_fire) begin
					state_next = FBP_ST_IDLE;
				end
			end
			default: state_next = FBP_ST_IDLE;
		endcase
	end

	// Sequencer registers; erase walks only the 256 words of one 1 KB block
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state_reg <= FBP_ST_IDLE;
			cnt_reg <= 16'h0000;
			ewrd_reg <= 10'h000;
			blk_reg <= 6'h00;
			pwrd_reg <= 14'h0000;
			pdata_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			if (wr_start) begin
				blk_reg <= i_wr.addr[15:`FBP_BLOCK_LSB];
				pwrd_reg <= i_wr.addr[15:2];
				pdata_reg <= i_wr.data;
				ewrd_reg <= 10'h000;
				cnt_reg <= `FBP_PROG_CYCLES - 16'h0001;
			end else begin
				if (erasing) begin
					ewrd_reg <= ewrd_reg + 10'h001;
				end
				if (cnt_reg != 16'h0000) begin
					cnt_reg <= cnt_reg - 16'h0001;
				end
			end
		end
	end

	// Status outputs, all registered
	// Busy follows the next state so it rises on the edge a job is taken,
	// and drops on the same edge as done rises
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_wr_busy <= 1'b0;
			o_wr_done <= 1'b0;
			o_wr_rejected <= 1'b0;
			rd_pend_reg <= 1'b0;
			rd_deny_reg <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_denied <= 1'b0;
			o_rd_data <= 32'h0000_0000;
		end else begin
			o_wr_busy <= state_next != FBP_ST_IDLE;
			o_wr_done <= erase_last || prog_fire;
			o_wr_rejected <= wr_reject;
			rd_pend_reg <= i_rd.valid;
			rd_deny_reg <= i_rd.valid && rd_deny;
			o_rd_valid <= rd_pend_reg && !rd_deny_reg;
			o_rd_denied <= rd_deny_reg;
			// Denied reads return zero so no protected data leaks
			o_rd_data <= (rd_pend_reg && !rd_deny_reg) ? arr_data : 32'h0000_0000;
		end
	end
endmodule : fbp_ctrl

// [sim/fbp_host.sv]
// Requester model for fetch, data and debug reads
`timescale 1ns/100ps
module fbp_host import fbp_pkg::*; (
	input wire logic i_go,
	input wire logic [1:0] i_src,
	input wire logic [15:0] i_addr,
	output fbp_rd_req_s o_rd
);
	// Idle lines show inverted values, so a stale address is never taken for a request
	assign o_rd = '{i_go, fbp_src_e'(i_go ? i_src : ~i_src), i_go ? i_addr : ~i_addr};
endmodule : fbp_host

// [sim/fbp_ctrl_assertions.sv]
// Port assertions for the flash protection controller
`timescale 1ns/100ps
module fbp_ctrl_assertions import fbp_pkg::*; #(
	parameter int NUM_GRAN = 32
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [2*NUM_GRAN-1:0] i_prot,
	input wire fbp_rd_req_s i_rd,
	input wire logic o_rd_valid,
	input wire logic o_rd_denied,
	input wire logic [31:0] o_rd_data,
	input wire fbp_wr_req_s i_wr,
	input wire logic o_wr_busy,
	input wire logic o_wr_done,
	input wire logic o_wr_rejected
);
	// Protection code of the granule each request targets
	wire [1:0] rp = i_prot[{i_rd.addr[15:11], 1'b0} +: 2];
	wire [1:0] wp = i_prot[{i_wr.addr[15:11], 1'b0} +: 2];
	wire wlock = (wp == FBP_PROT_RO) || (wp == FBP_PROT_XO);
	wire wgo = i_wr.valid && !o_wr_busy;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	property p_rd_lat; i_rd.valid |-> ##2 (o_rd_valid ^ o_rd_denied); endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read not answered once");
	property p_xo_deny; i_rd.valid && rp == FBP_PROT_XO && i_rd.src != FBP_SRC_FETCH |-> ##2 o_rd_denied; endproperty
	a_xo_deny: assert property (p_xo_deny) else $error("read of fetch-only granule");
	property p_fetch; i_rd.valid && i_rd.src == FBP_SRC_FETCH |-> ##2 o_rd_valid; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch refused");
	property p_rd_ok; i_rd.valid && rp != FBP_PROT_XO |-> ##2 o_rd_valid; endproperty
	a_rd_ok: assert property (p_rd_ok) else $error("plain read refused");
	property p_den_zero; o_rd_denied |-> o_rd_data == 32'h0; endproperty
	a_den_zero: assert property (p_den_zero) else $error("denied read leaks data");
	property p_wr_rej; wgo && wlock |=> o_wr_rejected && !o_wr_busy; endproperty
	a_wr_rej: assert property (p_wr_rej) else $error("locked write not refused");
	property p_prog; wgo && !wlock && !i_wr.erase |=> o_wr_busy [*4] ##1 (o_wr_done && !o_wr_busy); endproperty
	a_prog: assert property (p_prog) else $error("program timing wrong");
	property p_erase; wgo && !wlock && i_wr.erase |-> ##257 o_wr_done; endproperty
	a_erase: assert property (p_erase) else $error("erase timing wrong");
	// Main scenarios reached
	c_deny: cover property (o_rd_denied);
	c_rej: cover property (o_wr_rejected);
	c_done: cover property (o_wr_done);
endmodule : fbp_ctrl_assertions
bind fbp_ctrl fbp_ctrl_assertions #(.NUM_GRAN(NUM_GRAN)) u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_prot(i_prot), .i_rd(i_rd), .o_rd_valid(o_rd_valid), .o_rd_denied(o_rd_denied), .o_rd_data(o_rd_data),
	.i_wr(i_wr), .o_wr_busy(o_wr_busy), .o_wr_done(o_wr_done), .o_wr_rejected(o_wr_rejected));

// [sim/fbp_ctrl_tb.sv]
// Self-checking bench for the flash protection controller
`timescale 1ns/100ps
module fbp_ctrl_tb import fbp_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [63:0] prot = 64'h0;
	logic go = 1'b0;
	logic [1:0] src = 2'h0;
	logic [15:0] ra = 16'h0;
	fbp_rd_req_s rd;
	fbp_wr_req_s wr = '0;
	logic rv, rdn, wb, wd, wrj;
	logic [31:0] rdat;
	int failures = 0;
	int num_checks = 0;
	always #2.5 clk = ~clk;
	fbp_host host (.i_go(go), .i_src(src), .i_addr(ra), .o_rd(rd));
	fbp_ctrl dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_prot(prot), .i_rd(rd), .o_rd_valid(rv), .o_rd_denied(rdn),
		.o_rd_data(rdat), .i_wr(wr), .o_wr_busy(wb), .o_wr_done(wd), .o_wr_rejected(wrj));
	task ck(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask : ck
	// One write or erase, waited on under a bound
	task wr_op(input logic e, input logic [15:0] a, input logic [31:0] d, input logic rj);
		int n;
		n = 0;
		@(posedge clk) #1 wr = '{1'b1, e, a, d};
		@(posedge clk) #1 wr.valid = 1'b0;
		ck({31'h0, wb}, {31'h0, ~rj});
		while (wd !== 1'b1 && wrj !== 1'b1 && n < 300) begin
			@(posedge clk) #1 n++;
		end
		// A timed-out job shows neither flag and fails here
		ck({30'h0, wd, wrj}, {30'h0, ~rj, rj});
	endtask : wr_op
	// One read, answer looked at while it stands, before the second edge after it is taken
	task rd_op(input logic [1:0] s, input logic [15:0] a, input logic dn, input logic [31:0] d);
		@(posedge clk) #1 ra = a;
		src = s;
		go = 1'b1;
		@(posedge clk) #1 go = 1'b0;
		@(posedge clk) #1 ck({30'h0, rv, rdn}, {30'h0, ~dn, dn});
		ck(rdat, d);
	endtask : rd_op
	task s_erase;
		wr_op(1'b1, 16'h0000, 32'h0, 1'b0);
		wr_op(1'b1, 16'h0400, 32'h0, 1'b0);
		rd_op(2'h1, 16'h07fc, 1'b0, 32'hffff_ffff);
	endtask : s_erase
	// Programming ANDs; erasing the neighbour block spares it
	task s_prog;
		wr_op(1'b0, 16'h0004, 32'h1234_5678, 1'b0);
		wr_op(1'b0, 16'h0004, 32'hff00_ffff, 1'b0);
		wr_op(1'b1, 16'h0400, 32'h0, 1'b0);
		rd_op(2'h1, 16'h0004, 1'b0, 32'h1200_5678);
	endtask : s_prog
	task s_ro;
		prot = 64'h1;
		wr_op(1'b0, 16'h0004, 32'h0, 1'b1);
		wr_op(1'b1, 16'h0000, 32'h0, 1'b1);
		rd_op(2'h2, 16'h0004, 1'b0, 32'h1200_5678);
	endtask : s_ro
	task s_xo;
		prot = 64'h2;
		wr_op(1'b1, 16'h0400, 32'h0, 1'b1);
		rd_op(2'h0, 16'h0004, 1'b0, 32'h1200_5678);
		rd_op(2'h1, 16'h0004, 1'b1, 32'h0);
		rd_op(2'h2, 16'h0004, 1'b1, 32'h0);
	endtask : s_xo
	// A neighbouring granule keeps its own setting
	task s_gran;
		wr_op(1'b1, 16'h0800, 32'h0, 1'b0);
		rd_op(2'h1, 16'h0800, 1'b0, 32'hffff_ffff);
	endtask : s_gran
	task summarize;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		s_erase();
		s_prog();
		s_ro();
		s_xo();
		s_gran();
		summarize();
	end
	// Bound on the whole run, about ten times the expected length
	initial begin
		#60000;
		failures++;
		summarize();
	end
endmodule : fbp_ctrl_tb
